/* File: core/gpc_gpio_pin_config.sv */
// Configuration, drive, sensing and edge events for general purpose pins
`timescale 1ns/1ps

module gpc_gpio_pin_config
  import gpc_pkg::*;
#(
  parameter int unsigned         MS_CYCLES    = MS_CYCLES_DFLT,
  parameter logic [NUM_PINS-1:0] ALT_IS_INPUT = 2'h0
)
(
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  // Register access port
  input  wire gpc_reg_req_t        REG_REQ,
  output logic [7:0]               REG_RDATA,
  output logic                     REG_RVALID,
  // Pins
  input  wire logic [NUM_PINS-1:0] PIN_IN,
  output logic [NUM_PINS-1:0]      PIN_OUT,
  output logic [NUM_PINS-1:0]      PIN_OE,
  // Alternate function path
  input  wire logic [NUM_PINS-1:0] ALT_EN,
  input  wire logic [NUM_PINS-1:0] ALT_OUT_LEVEL,
  output logic [NUM_PINS-1:0]      ALT_IN,
  // Edge events
  output logic [NUM_PINS-1:0]      EDGE_PEND,
  input  wire logic [NUM_PINS-1:0] EDGE_ACK
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (MS_CYCLES < 1 || MS_CYCLES >= (1 << DIV_W)) begin : g_bad_ms
    $error("MS_CYCLES out of range for the divider");
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a, input int p);
    addr_hit = (p == 0) ? (a == PIN1_CFG_ADDR) : (a == PIN2_CFG_ADDR);
  endfunction

  gpc_state_t          st;
  gpc_state_t          next_st;
  logic [NUM_PINS-1:0] dbn_level;
  logic [NUM_PINS-1:0] gp_input;
  logic [NUM_PINS-1:0] drive_level;
  logic [NUM_PINS-1:0] drive_push;
  logic [NUM_PINS-1:0] drive_on;

  // ----------------------------------------------------------------------
  // Pin role and debounce per pin
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    logic [1:0] debounce_time_select_code;

    // General purpose input only when the alternate function is off
    assign gp_input[i] = ~ALT_EN[i] & (st.cfg[i].dir == DIR_INPUT);

    // Output pins see no filter, so a later switch to input starts clean
    assign debounce_time_select_code = gp_input[i] ? st.cfg[i].debounce_time_select
                                   : DEBOUNCE_TIME_SELECT_NONE;

    gpc_debounce u_debounce_time_select (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ms_tick (st.tick),
      .code    (debounce_time_select_code),
      .raw     (st.sync2[i]),
      .level   (dbn_level[i])
    );
  end

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (ALT_EN[i] && !ALT_IS_INPUT[i]) begin
        // Alternate outputs are active-high regardless of direction bit
        drive_level[i] = ALT_OUT_LEVEL[i];
        drive_on[i]    = 1'b1;
      end else if (ALT_EN[i]) begin
        drive_level[i] = 1'b0;
        drive_on[i]    = 1'b0;
      end else begin
        drive_level[i] = st.cfg[i].out_level;
        drive_on[i]    = ~gp_input[i];
      end
      // Drive type only counts while driving; inputs never look at it
      drive_push[i] = drive_on[i] &
                      (st.cfg[i].drive_type_bit == DRV_PUSH);
    end
  end

  // On a driving pin low is always driven; high is driven only in push-pull mode; input pins are never driven
  assign PIN_OUT = drive_level & drive_on;
  assign PIN_OE  = drive_on & (~drive_level | drive_push);

  // ----------------------------------------------------------------------
  // Alternate inputs
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (ALT_EN[i] && ALT_IS_INPUT[i]) begin
        // Direction bit one keeps the level, zero inverts it
        ALT_IN[i] = (st.cfg[i].dir == DIR_INPUT) ? st.sync2[i]
                                                  : ~st.sync2[i];
      end else begin
        ALT_IN[i] = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic hit;
    rise    = 1'b0;
    fall    = 1'b0;
    hit     = 1'b0;
    next_st = st;

    // Two-stage synchroniser on the pin levels
    next_st.sync1 = PIN_IN;
    next_st.sync2 = st.sync1;

    // Millisecond tick divider
    if (st.div == DIV_W'(MS_CYCLES - 1)) begin
      next_st.div  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.div  = DIV_W'(st.div + 14'h0001);
      next_st.tick = 1'b0;
    end

    // Edge detection on the filtered level
    next_st.prev = dbn_level;
    for (int i = 0; i < NUM_PINS; i++) begin
      rise = dbn_level[i] & ~st.prev[i];
      fall = ~dbn_level[i] & st.prev[i];
      unique case (st.cfg[i].edge_interrupt_select)
        EDGE_NONE: hit = 1'b0;
        EDGE_FALL: hit = fall;
        EDGE_RISE: hit = rise;
        EDGE_BOTH: hit = rise | fall;
      endcase
      // Output pins never raise an event
      hit = hit & gp_input[i];
      // A new edge in the acknowledge cycle stays pending
      if (EDGE_ACK[i]) begin
        next_st.pend[i] = 1'b0;
      end
      if (hit) begin
        next_st.pend[i] = 1'b1;
      end
    end

    // Register writes; the input level bit is never stored
    for (int i = 0; i < NUM_PINS; i++) begin
      if (REG_REQ.wr && addr_hit(REG_REQ.addr, i)) begin
        next_st.cfg[i].debounce_time_select =
          REG_REQ.wdata[DEBOUNCE_TIME_SELECT_HI:DEBOUNCE_TIME_SELECT_LO];
        next_st.cfg[i].edge_interrupt_select =
          REG_REQ.wdata[EDGE_HI:EDGE_LO];
        next_st.cfg[i].out_level      = REG_REQ.wdata[LEVEL_BIT];
        next_st.cfg[i].dir            = REG_REQ.wdata[DIR_BIT];
        next_st.cfg[i].drive_type_bit = REG_REQ.wdata[DRIVE_BIT];
      end
    end

    // Register reads, answered on the next edge
    next_st.rvalid = REG_REQ.rd;
    if (REG_REQ.rd) begin
      next_st.rdata = 8'h00;
      for (int i = 0; i < NUM_PINS; i++) begin
        if (addr_hit(REG_REQ.addr, i)) begin
          next_st.rdata[DEBOUNCE_TIME_SELECT_HI:DEBOUNCE_TIME_SELECT_LO] =
            st.cfg[i].debounce_time_select;
          next_st.rdata[EDGE_HI:EDGE_LO] =
            st.cfg[i].edge_interrupt_select;
          next_st.rdata[LEVEL_BIT] = st.cfg[i].out_level;
          // Sensed level; for output pins it is the unfiltered synchronised pin level
          next_st.rdata[INPUT_BIT] = dbn_level[i];
          next_st.rdata[DIR_BIT]   = st.cfg[i].dir;
          next_st.rdata[DRIVE_BIT] = st.cfg[i].drive_type_bit;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA  = st.rdata;
  assign REG_RVALID = st.rvalid;
  assign EDGE_PEND  = st.pend;

endmodule

/* File: core/gpc_pkg.sv */
// Package: register map, field layout, timing and carrier types
package gpc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIN1_CFG_ADDR  = 8'h71;
  localparam logic [7:0] PIN2_CFG_ADDR  = 8'h72;
  localparam logic [7:0] PIN_CFG_RESET  = 8'h00;
  localparam int         NUM_PINS       = 2;

  // ----------------------------------------------------------------------
  // Field positions inside a pin configuration register
  // ----------------------------------------------------------------------
  localparam int DEBOUNCE_TIME_SELECT_HI   = 7;
  localparam int DEBOUNCE_TIME_SELECT_LO   = 6;
  localparam int EDGE_HI   = 5;
  localparam int EDGE_LO   = 4;
  localparam int LEVEL_BIT = 3;
  localparam int INPUT_BIT = 2;
  localparam int DIR_BIT   = 1;
  localparam int DRIVE_BIT = 0;

  // ----------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] DEBOUNCE_TIME_SELECT_NONE  = 2'h0;
  localparam logic [1:0] DEBOUNCE_TIME_SELECT_8MS   = 2'h1;
  localparam logic [1:0] DEBOUNCE_TIME_SELECT_16MS  = 2'h2;
  localparam logic [1:0] DEBOUNCE_TIME_SELECT_32MS  = 2'h3;
  localparam logic [1:0] EDGE_NONE  = 2'h0;
  localparam logic [1:0] EDGE_FALL  = 2'h1;
  localparam logic [1:0] EDGE_RISE  = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;
  localparam logic       DIR_OUTPUT = 1'h0;
  localparam logic       DIR_INPUT  = 1'h1;
  localparam logic       DRV_OPEN   = 1'h0;
  localparam logic       DRV_PUSH   = 1'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 100;
  localparam int         MS_NS          = 1000000;
  localparam int         MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;
  localparam int         DIV_W          = 14;
  localparam int         TICK_W         = 6;
  localparam logic [5:0] DEBOUNCE_TIME_SELECT_8_TICKS   = 6'h08;
  localparam logic [5:0] DEBOUNCE_TIME_SELECT_16_TICKS  = 6'h10;
  localparam logic [5:0] DEBOUNCE_TIME_SELECT_32_TICKS  = 6'h20;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] debounce_time_select;
    logic [1:0] edge_interrupt_select;
    logic       out_level;
    logic       dir;
    logic       drive_type_bit;
  } gpc_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpc_reg_req_t;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              level;
  } gpc_debounce_time_select_state_t;

  typedef struct packed {
    gpc_cfg_t [NUM_PINS-1:0] cfg;
    logic [NUM_PINS-1:0]     sync1;
    logic [NUM_PINS-1:0]     sync2;
    logic [NUM_PINS-1:0]     prev;
    logic [NUM_PINS-1:0]     pend;
    logic [DIV_W-1:0]        div;
    logic                    tick;
    logic [7:0]              rdata;
    logic                    rvalid;
  } gpc_state_t;

endpackage

/* File: core/gpc_debounce.sv */
// Debounce filter for one synchronised pin level
`timescale 1ns/1ps
module gpc_debounce
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Millisecond tick and filter selection
  input  wire logic       ms_tick,
  input  wire logic [1:0] code,
  // Level in and filtered level out
  input  wire logic       raw,
  output logic            level
);

  // ----------------------------------------------------------------------
  // Filter length in millisecond ticks
  // ----------------------------------------------------------------------
  function automatic logic [TICK_W-1:0] ticks_of(input logic [1:0] c);
    unique case (c)
      DEBOUNCE_TIME_SELECT_8MS:  ticks_of = DEBOUNCE_TIME_SELECT_8_TICKS;
      DEBOUNCE_TIME_SELECT_16MS: ticks_of = DEBOUNCE_TIME_SELECT_16_TICKS;
      DEBOUNCE_TIME_SELECT_32MS: ticks_of = DEBOUNCE_TIME_SELECT_32_TICKS;
      DEBOUNCE_TIME_SELECT_NONE: ticks_of = '0;
    endcase
  endfunction

  gpc_debounce_time_select_state_t st;
  gpc_debounce_time_select_state_t next_st;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Counting whole ticks makes the filter up to one tick short; the
  // divider keeps counting so a free-running tick is cheaper than a reset.
  always_comb begin
    next_st = st;
    if (code == DEBOUNCE_TIME_SELECT_NONE) begin
      next_st.level = raw;
      next_st.cnt   = '0;
    end else if (raw == st.level) begin
      next_st.cnt = '0;
    end else if (ms_tick) begin
      if (TICK_W'(st.cnt + 6'h01) >= ticks_of(code)) begin
        next_st.level = raw;
        next_st.cnt   = '0;
      end else begin
        next_st.cnt = TICK_W'(st.cnt + 6'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

/* File: testbench/gpc_pin_model.sv */
// Outside world of the pins: drive, outside driver and pull-up or pull-down
`timescale 1ns/1ps
module gpc_pin_model
  import gpc_pkg::*;
(
  // Device side
  input  wire logic [NUM_PINS-1:0] oe,
  input  wire logic [NUM_PINS-1:0] out,
  // Outside driver
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_lvl,
  // Pull selected by the bench through pull_dn: pull-down when set, pull-up when clear
  input  wire logic [NUM_PINS-1:0] pull_dn,
  output logic [NUM_PINS-1:0]      level
);
  // Released line rests on its pull: level bit 1 with pull-up
  // level bit 0 with pull-down
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      level[i] = oe[i] ? out[i]
               : (ext_en[i] ? ext_lvl[i] : ~pull_dn[i]);
    end
  end
endmodule

/* File: testbench/gpc_gpio_pin_config_props.sv */
// Checker for register answers, pin drive and edge events
`timescale 1ns/1ps
module gpc_props
  import gpc_pkg::*;
#(
  parameter int unsigned         MS_CYCLES    = 4,
  parameter logic [NUM_PINS-1:0] ALT_IS_INPUT = 2'h0
)
(
  // Clock, reset, registers
  input wire logic                CLK,
  input wire logic                RESET_N,
  input wire gpc_reg_req_t        REG_REQ,
  input wire logic [7:0]          REG_RDATA,
  input wire logic                REG_RVALID,
  // Pins, alternate path, events
  input wire logic [NUM_PINS-1:0] PIN_IN,
  input wire logic [NUM_PINS-1:0] PIN_OUT,
  input wire logic [NUM_PINS-1:0] PIN_OE,
  input wire logic [NUM_PINS-1:0] ALT_EN,
  input wire logic [NUM_PINS-1:0] ALT_OUT_LEVEL,
  input wire logic [NUM_PINS-1:0] ALT_IN,
  input wire logic [NUM_PINS-1:0] EDGE_PEND,
  input wire logic [NUM_PINS-1:0] EDGE_ACK
);
  logic [NUM_PINS-1:0][7:0] sh;
  logic [7:0]               rsel;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Shadow of stored fields; the sensed bit is never stored
  always_ff @(posedge CLK) begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!RESET_N) begin
        sh[i] <= PIN_CFG_RESET;
      end else if (REG_REQ.wr && REG_REQ.addr == PIN1_CFG_ADDR + 8'(i)) begin
        sh[i] <= REG_REQ.wdata & 8'hfb;
      end
    end
  end
  assign rsel = REG_REQ.addr == PIN1_CFG_ADDR ? sh[0]
              : REG_REQ.addr == PIN2_CFG_ADDR ? sh[1] : 8'h00;
  a_read_answered: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read not answered");
  a_answer_cause: assert property (REG_RVALID |-> $past(REG_REQ.rd))
    else $error("unrequested read answer");
  a_read_back: assert property (
    REG_RVALID |-> (REG_RDATA & 8'hfb) == $past(rsel))
    else $error("stored fields read back wrong");
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    wire general_purpose_output = !sh[i][DIR_BIT] && !ALT_EN[i];
    a_push_drive: assert property (
      general_purpose_output && sh[i][0] |-> PIN_OE[i] && PIN_OUT[i] == sh[i][3])
      else $error("push-pull drive wrong");
    a_open_drain: assert property (
      general_purpose_output && !sh[i][DRIVE_BIT] |-> PIN_OE[i] == !sh[i][LEVEL_BIT] &&
      !(PIN_OE[i] && PIN_OUT[i]))
      else $error("open-drain drive wrong");
    a_input_float: assert property (
      sh[i][DIR_BIT] && !ALT_EN[i] |-> !PIN_OE[i])
      else $error("input pin driven");
    a_pend_hold: assert property (
      EDGE_PEND[i] && !EDGE_ACK[i] |=> EDGE_PEND[i])
      else $error("pending event lost");
    a_pend_clear: assert property (
      $fell(EDGE_PEND[i]) |-> $past(EDGE_ACK[i]))
      else $error("pending event cleared without ack");
    a_event_cause: assert property ($rose(EDGE_PEND[i]) |->
      $past(sh[i][DIR_BIT] && sh[i][5:4] != EDGE_NONE && !ALT_EN[i]))
      else $error("event from masked or output pin");
  end
  c_read: cover property (REG_RVALID);
  c_event: cover property ($rose(EDGE_PEND[1]));
  c_alt: cover property (ALT_EN[0] && PIN_OE[0]);
endmodule
bind gpc_gpio_pin_config gpc_props #(
  .MS_CYCLES(MS_CYCLES), .ALT_IS_INPUT(ALT_IS_INPUT)
) props_u (
  .CLK(CLK), .RESET_N(RESET_N), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE(PIN_OE), .ALT_EN(ALT_EN), .ALT_OUT_LEVEL(ALT_OUT_LEVEL),
  .ALT_IN(ALT_IN), .EDGE_PEND(EDGE_PEND), .EDGE_ACK(EDGE_ACK)
);

/* File: testbench/gpc_gpio_pin_config_tb.sv */
// Self-checking bench for the pin configuration unit
`timescale 1ns/1ps
`define CHK(a, e, m) begin total_checks++; if ((a) !== (e)) begin \
  n_errors++; $display("mismatch t=%0t %s", $time, m); end end
module gpc_gpio_pin_config_tb
  import gpc_pkg::*;
;
  // Short millisecond keeps the longest filter near 130 cycles
  localparam int MSC = 4;
  logic         CLK;
  logic         RESET_N;
  gpc_reg_req_t req;
  logic [7:0]   rdata;
  logic         rvalid;
  logic [1:0]   pin_in, pin_out, pin_oe, alt_en, alt_lvl, alt_in;
  logic [1:0]   pend, ack, ext_en, ext_lvl;
  logic [1:0]   pull_dn;
  logic [1:0]   seen;
  int           n_errors = 0;
  int           total_checks = 0;
  int           n;
  gpc_gpio_pin_config #(.MS_CYCLES(MSC), .ALT_IS_INPUT(2'h2)) dut_u (
    .CLK(CLK), .RESET_N(RESET_N), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .ALT_EN(alt_en), .ALT_OUT_LEVEL(alt_lvl),
    .ALT_IN(alt_in), .EDGE_PEND(pend), .EDGE_ACK(ack));
  gpc_pin_model pins_u (.oe(pin_oe), .out(pin_out), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pull_dn(pull_dn), .level(pin_in));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // One write (w=1) or read with expected data; entered and left at an edge
  task automatic acc(input logic w, input logic [7:0] a, d, e);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge CLK);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1 if (!w) `CHK({rvalid, rdata}, {1'b1, e}, "read data")
    @(posedge CLK);
  endtask
  // Move a pin, check the event after n cycles, then acknowledge it
  task automatic pin_step(input int i, input logic v, e, input int n);
    ext_lvl[i] <= v;
    repeat (n) @(posedge CLK);
    #1 `CHK(pend[i], e, "edge event")
    @(posedge CLK);
    ack[i] <= 1'b1;
    @(posedge CLK);
    ack[i] <= 1'b0;
    @(posedge CLK);
    #1 `CHK(pend[i], 1'b0, "event not cleared")
    @(posedge CLK);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    RESET_N = 1'b0;
    req = '0;
    {alt_en, alt_lvl, ack, ext_lvl, pull_dn} = '0;
    ext_en = 2'h3;
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    `CHK({pin_oe, pin_out}, 4'hc, "reset drive")
    acc(1, 8'h73, 8'hff, 0);
    acc(0, 8'h73, 0, 8'h00);
    acc(0, PIN1_CFG_ADDR, 0, 8'h00);
    acc(0, PIN2_CFG_ADDR, 0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      acc(1, PIN2_CFG_ADDR, {4'h0, k[1], 2'h0, k[0]}, 0);
      n = (k == 2) ? 0 : 1;
      seen = {pin_oe[1], pin_oe[1] & pin_out[1]};
      `CHK(seen, {n[0], n[0] & k[1]}, "drive")
    end
    acc(1, PIN2_CFG_ADDR, 8'hf8, 0);
    ext_en[1] <= 1'b0;
    repeat (4) @(posedge CLK);
    acc(0, PIN2_CFG_ADDR, 0, 8'hfc);
    ext_en[1] <= 1'b1;
    pin_step(1, 0, 0, 8);
    acc(1, PIN2_CFG_ADDR, 8'h06, 0);
    acc(0, PIN2_CFG_ADDR, 0, 8'h02);
    ext_lvl[1] <= 1'b1;
    repeat (6) @(posedge CLK);
    acc(0, PIN2_CFG_ADDR, 0, 8'h06);
    // Released input with level bit one rests on its pull-down
    acc(1, PIN2_CFG_ADDR, 8'h0a, 0);
    ext_en[1] <= 1'b0;
    pull_dn[1] <= 1'b1;
    repeat (6) @(posedge CLK);
    acc(0, PIN2_CFG_ADDR, 0, 8'h0a);
    `CHK(pend[1], 1'b0, "masked edge")
    ext_en[1] <= 1'b1;
    pull_dn[1] <= 1'b0;
    repeat (6) @(posedge CLK);
    for (int c = 0; c < 4; c++) begin
      acc(1, PIN2_CFG_ADDR, {2'h0, c[1:0], 4'h2}, 0);
      pin_step(1, 0, c[0], 6);
      pin_step(1, 1, c[1], 6);
    end
    pin_step(1, 0, 1, 6);
    for (int d = 1; d < 4; d++) begin
      n = (8 << (d - 1)) * MSC;
      acc(1, PIN2_CFG_ADDR, {d[1:0], 2'h3, 4'h2}, 0);
      ext_lvl[1] <= 1'b1;
      repeat (n - MSC - 2) @(posedge CLK);
      pin_step(1, 0, 0, n + 8);
      pin_step(1, 1, 1, n + 8);
      pin_step(1, 0, 1, n + 8);
    end
    alt_en <= 2'h3;
    alt_lvl <= 2'h1;
    ext_lvl[1] <= 1'b1;
    acc(1, PIN1_CFG_ADDR, 8'h01, 0);
    acc(1, PIN2_CFG_ADDR, 8'h00, 0);
    repeat (4) @(posedge CLK);
    `CHK({pin_oe, pin_out[0], alt_in[1]}, 4'b0110, "alternate")
    acc(1, PIN2_CFG_ADDR, 8'h02, 0);
    `CHK(alt_in[1], 1'b1, "alternate polarity")
    test_done();
  end
endmodule
